// ---- shared/sfst_pkg.sv ----
// constants for the status flag and sample timing block
package sfst_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_STATUS2 = 8'h05;
	localparam logic [7:0] ADDR_WMARK = 8'h39;
	localparam logic [7:0] ADDR_BUFCTL = 8'h3a;
	localparam logic [7:0] ADDR_TIMING = 8'h3d;
	localparam logic [7:0] WMARK_RESET = 8'h80;
	localparam logic [7:0] BUFCTL_RESET = 8'h00;
	localparam logic [7:0] TIMING_RESET = 8'h00;
	// ****************************************
	// field positions
	// ****************************************
	localparam int BIT_TRIG_ENABLE = 0;
	localparam int BIT_TIMEBASE_SEL = 1;
	localparam int BIT_WM_MSB = 0;
	localparam int BIT_MODE_LO = 1;
	localparam int BIT_NEW = 0;
	localparam int BIT_BRDY = 1;
	localparam int BIT_WM = 2;
	localparam int BIT_OVR = 3;
	localparam int BIT_QUIET = 4;
	localparam int BIT_MOTION = 5;
	localparam int NUM_FLAGS = 6;
	// ****************************************
	// buffer modes and time base
	// ****************************************
	typedef enum logic [1:0] {SFST_OFF, SFST_STREAM, SFST_TRIG, SFST_OLDEST} sfst_mode_t;
	localparam int CLK_HZ = 20000000;
	localparam int BASE_HZ = 307200;
	localparam int FAST_HZ = 614400;
	localparam int BASE_DIV = CLK_HZ / BASE_HZ;
	localparam int FAST_DIV = CLK_HZ / FAST_HZ;
	localparam logic [9:0] TICKS_SLOW = 10'h300;
	localparam logic [2:0] RATE_FAST = 3'h4;
	localparam logic [2:0] MAX_SHIFT = 3'h3;
endpackage

// ---- rtl/sfst_top.sv ----
// status flags, interrupt pins and sampling time base
`timescale 1ns/1ns
module sfst_top
	import sfst_pkg::*;
#(
	parameter int COUNT_W = 10
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic motion_event,
	input wire logic quiet_event,
	input wire logic result_ready,
	input wire logic result_read_active,
	input wire logic [COUNT_W-1:0] buffer_count,
	input wire logic buffer_write,
	input wire logic buffer_full,
	input wire logic buffer_trigger_saved,
	input wire logic [2:0] output_sample_rate,
	input wire logic [NUM_FLAGS-1:0] irq_map_a,
	input wire logic [NUM_FLAGS-1:0] irq_map_b,
	input wire logic irq_pin_a_in,
	output logic irq_pin_a_out,
	output logic irq_pin_a_oe,
	input wire logic irq_pin_b_in,
	output logic irq_pin_b_out,
	output logic irq_pin_b_oe,
	output logic [1:0] buffer_mode,
	output logic sample_start
);
	// ****************************************
	// registers
	// ****************************************
	logic [7:0] wmark_reg;
	logic [7:0] bufctl_reg;
	logic [7:0] timing_reg;
	logic [7:0] rdata_reg;
	logic [NUM_FLAGS-1:0] flags;
	logic new_reg, pend_reg, rd_q_reg;
	logic brdy_reg, wm_reg, ovr_reg, quiet_reg, motion_reg;
	logic status_rd, status2_rd, read_start, read_end;
	logic wm_cond, rdy_cond, ovr_event, external_timebase_select, sample_trigger_enable;
	logic [8:0] wm_thresh;

	assign status_rd = reg_rd && (reg_addr == ADDR_STATUS);
	assign status2_rd = reg_rd && (reg_addr == ADDR_STATUS2);
	assign external_timebase_select = timing_reg[BIT_TIMEBASE_SEL];
	assign sample_trigger_enable = timing_reg[BIT_TRIG_ENABLE];
	assign buffer_mode = bufctl_reg[BIT_MODE_LO+1:BIT_MODE_LO];
	assign reg_rdata = rdata_reg;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wmark_reg <= WMARK_RESET;
			bufctl_reg <= BUFCTL_RESET;
			timing_reg <= TIMING_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_WMARK: wmark_reg <= reg_wdata;
				ADDR_BUFCTL: bufctl_reg <= reg_wdata;
				ADDR_TIMING: timing_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_STATUS: rdata_reg <= {4'h0, ovr_reg, wm_reg, brdy_reg, new_reg};
				ADDR_STATUS2: rdata_reg <= {2'h0, motion_reg, quiet_reg, 4'h0};
				ADDR_WMARK: rdata_reg <= wmark_reg;
				ADDR_BUFCTL: rdata_reg <= bufctl_reg;
				ADDR_TIMING: rdata_reg <= timing_reg;
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	// ****************************************
	// detector flags
	// ****************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			motion_reg <= 1'b0;
			quiet_reg <= 1'b0;
		end else begin
			if (motion_event) begin
				motion_reg <= 1'b1;
			end else if (status2_rd) begin
				motion_reg <= 1'b0;
			end
			if (quiet_event) begin
				quiet_reg <= 1'b1;
			end else if (status2_rd) begin
				quiet_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// new sample flag
	// ****************************************
	assign read_start = result_read_active && !rd_q_reg;
	assign read_end = rd_q_reg && !result_read_active;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_q_reg <= 1'b0;
			pend_reg <= 1'b0;
			new_reg <= 1'b0;
		end else begin
			rd_q_reg <= result_read_active;
			if (result_read_active) begin
				if (read_start) begin
					new_reg <= 1'b0;
				end
				if (result_ready) begin
					pend_reg <= 1'b1;
				end
			end else begin
				pend_reg <= 1'b0;
				if (result_ready || (read_end && pend_reg)) begin
					new_reg <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// buffer flags
	// ****************************************
	assign wm_thresh = {bufctl_reg[BIT_WM_MSB], wmark_reg};
	assign wm_cond = (buffer_count >= COUNT_W'(wm_thresh));
	assign rdy_cond = (buffer_count != '0)
		&& ((buffer_mode != SFST_TRIG) || buffer_trigger_saved);
	assign ovr_event = buffer_write && buffer_full && (buffer_mode != SFST_OFF);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wm_reg <= 1'b0;
			brdy_reg <= 1'b0;
			ovr_reg <= 1'b0;
		end else begin
			if (wm_cond) begin
				wm_reg <= 1'b1;
			end else if (status_rd) begin
				wm_reg <= 1'b0;
			end
			if (rdy_cond) begin
				brdy_reg <= 1'b1;
			end else if (status_rd) begin
				brdy_reg <= 1'b0;
			end
			if (ovr_event) begin
				ovr_reg <= 1'b1;
			end else if ((buffer_mode == SFST_OFF) || (status_rd && buffer_count == '0)) begin
				ovr_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// interrupt pins
	// ****************************************
	assign flags = {motion_reg, quiet_reg, ovr_reg, wm_reg, brdy_reg, new_reg};

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_pin_a_out <= 1'b0;
			irq_pin_a_oe <= 1'b0;
			irq_pin_b_out <= 1'b0;
			irq_pin_b_oe <= 1'b0;
		end else begin
			irq_pin_a_out <= |(flags & irq_map_a);
			irq_pin_b_out <= |(flags & irq_map_b);
			irq_pin_a_oe <= (irq_map_a != '0) && !external_timebase_select;
			irq_pin_b_oe <= (irq_map_b != '0) && !sample_trigger_enable;
		end
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [1:0] pin_a_sync_reg, pin_b_sync_reg;
	logic pin_a_q_reg, pin_b_q_reg;
	logic ext_tick, sync_rise;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_a_sync_reg <= 2'b00;
			pin_b_sync_reg <= 2'b00;
			pin_a_q_reg <= 1'b0;
			pin_b_q_reg <= 1'b0;
		end else begin
			pin_a_sync_reg <= {pin_a_sync_reg[0], irq_pin_a_in};
			pin_b_sync_reg <= {pin_b_sync_reg[0], irq_pin_b_in};
			pin_a_q_reg <= pin_a_sync_reg[1];
			pin_b_q_reg <= pin_b_sync_reg[1];
		end
	end

	assign ext_tick = external_timebase_select && pin_a_sync_reg[1] && !pin_a_q_reg;
	assign sync_rise = sample_trigger_enable && pin_b_sync_reg[1] && !pin_b_q_reg;

	// ****************************************
	// time base and sample pacing
	// ****************************************
	logic [6:0] div_reg, div_lim;
	logic [9:0] tick_cnt_reg, tick_lim;
	logic [2:0] rate_shift;
	logic base_tick, tb_tick;

	assign div_lim = (output_sample_rate >= RATE_FAST) ? 7'(FAST_DIV - 1) : 7'(BASE_DIV - 1);
	assign base_tick = (div_reg >= div_lim);
	assign tb_tick = external_timebase_select ? ext_tick : base_tick;
	assign rate_shift = (output_sample_rate > MAX_SHIFT) ? MAX_SHIFT : output_sample_rate;
	assign tick_lim = 10'((TICKS_SLOW >> rate_shift) - 10'h001);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_reg <= 7'h00;
		end else if (base_tick) begin
			div_reg <= 7'h00;
		end else begin
			div_reg <= 7'(div_reg + 7'h01);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tick_cnt_reg <= 10'h000;
			sample_start <= 1'b0;
		end else begin
			sample_start <= 1'b0;
			if (sample_trigger_enable) begin
				tick_cnt_reg <= 10'h000;
				sample_start <= sync_rise;
			end else if (tb_tick) begin
				if (tick_cnt_reg >= tick_lim) begin
					tick_cnt_reg <= 10'h000;
					sample_start <= 1'b1;
				end else begin
					tick_cnt_reg <= 10'(tick_cnt_reg + 10'h001);
				end
			end
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	property p_new_set;
		@(posedge clk) disable iff (reset)
		(result_ready && !result_read_active) |=> new_reg;
	endproperty
	a_new_set: assert property (p_new_set) else $error("new flag not set");

	property p_no_set_in_read;
		@(posedge clk) disable iff (reset)
		result_read_active |=> !new_reg;
	endproperty
	a_no_set_in_read: assert property (p_no_set_in_read) else $error("flag set in read");

	property p_deferred;
		@(posedge clk) disable iff (reset)
		($fell(result_read_active) && pend_reg) |=> new_reg;
	endproperty
	a_deferred: assert property (p_deferred) else $error("deferred flag lost");

	property p_wm;
		@(posedge clk) disable iff (reset)
		(wm_thresh == 9'h000) |=> wm_reg;
	endproperty
	a_wm: assert property (p_wm) else $error("watermark not held");

	property p_rdy;
		@(posedge clk) disable iff (reset)
		(buffer_mode == SFST_TRIG && !buffer_trigger_saved && !brdy_reg)
			|=> !brdy_reg;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready before trigger");

	property p_ovr;
		@(posedge clk) disable iff (reset)
		ovr_event |=> ovr_reg ##1 (ovr_reg || $past(status_rd) || buffer_mode == SFST_OFF
			|| $past(buffer_mode) == SFST_OFF);
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrun not held");

	property p_ovr_off;
		@(posedge clk) disable iff (reset)
		(buffer_mode == SFST_OFF) [*2] |-> !ovr_reg;
	endproperty
	a_ovr_off: assert property (p_ovr_off) else $error("overrun kept while off");

	property p_pin_input;
		@(posedge clk) disable iff (reset)
		$past(external_timebase_select) |-> !irq_pin_a_oe;
	endproperty
	a_pin_input: assert property (p_pin_input) else $error("pin a drives as clock input");

	property p_pin_or;
		@(posedge clk) disable iff (reset)
		1'b1 |=> irq_pin_b_out == |($past(flags) & $past(irq_map_b));
	endproperty
	a_pin_or: assert property (p_pin_or) else $error("pin b not OR of sources");

	property p_sync;
		@(posedge clk) disable iff (reset)
		$rose(pin_b_q_reg) && $past(sample_trigger_enable) |-> sample_start;
	endproperty
	a_sync: assert property (p_sync) else $error("trigger edge without sample");

	property p_tick;
		@(posedge clk) disable iff (reset)
		base_tick |=> (!base_tick) [*8];
	endproperty
	a_tick: assert property (p_tick) else $error("time base too fast");
endmodule

// ---- verif/sfst_host.sv ----
// host model driving the clock and trigger pins
`timescale 1ns/1ns
module sfst_host #(
	parameter int HALF = 40,
	parameter int PULSE_W = 1080,
	parameter int GAP = 8100
) (
	input wire logic clk,
	input wire logic clk_en,
	output logic pin_a,
	output logic pin_b
);
	// ********
	// clock and trigger
	// ********
	initial begin
		pin_a = 1'b0;
		pin_b = 1'b0;
	end
	// below nominal rate, stands still while not selected
	always begin
		repeat (HALF) @(posedge clk);
		#2 pin_a = clk_en ? ~pin_a : 1'b0;
	end
	task automatic trig();
		@(posedge clk);
		#2 pin_b = 1'b1;
		repeat (PULSE_W) @(posedge clk);
		#2 pin_b = 1'b0;
		repeat (GAP) @(posedge clk);
	endtask
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the status flag block
`timescale 1ns/1ns
module tb_top;
	import sfst_pkg::*;
	logic clk, reset, reg_wr, reg_rd, motion_event, quiet_event, result_ready, ext_on;
	logic result_read_active, buffer_write, buffer_full, buffer_trigger_saved, pend;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, thr;
	logic [9:0] buffer_count;
	logic [2:0] output_sample_rate;
	logic [5:0] irq_map_a, irq_map_b;
	logic a_out, a_oe, b_out, b_oe, host_a, host_b, pin_a, pin_b, sample_start;
	logic [1:0] buffer_mode;
	logic [31:0] seed;
	logic [15:0] e;
	logic [15:0] exp_q[$];
	int err_count = 0;
	int total_checks = 0;
	int cyc_n = 0;
	int n_start = 0;
	int t0;
	// ********
	// design, host and pin levels
	// ********
	assign pin_a = a_oe ? a_out : host_a;
	assign pin_b = b_oe ? b_out : host_b;
	sfst_top #(.COUNT_W(10)) i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.motion_event(motion_event), .quiet_event(quiet_event), .result_ready(result_ready),
		.result_read_active(result_read_active), .buffer_count(buffer_count),
		.buffer_write(buffer_write), .buffer_full(buffer_full),
		.buffer_trigger_saved(buffer_trigger_saved), .output_sample_rate(output_sample_rate),
		.irq_map_a(irq_map_a), .irq_map_b(irq_map_b), .irq_pin_a_in(pin_a),
		.irq_pin_a_out(a_out), .irq_pin_a_oe(a_oe), .irq_pin_b_in(pin_b),
		.irq_pin_b_out(b_out), .irq_pin_b_oe(b_oe), .buffer_mode(buffer_mode),
		.sample_start(sample_start));
	sfst_host i_host (.clk(clk), .clk_en(ext_on), .pin_a(host_a), .pin_b(host_b));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc_n <= cyc_n + 1;
		if (sample_start === 1'b1) n_start <= n_start + 1;
		if (pend === 1'b1) begin
			e = exp_q.pop_front();
			chk("reg_rdata", e[7:0], reg_rdata & e[15:8]);
		end
		pend <= reg_rd;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic test_done();
		if (err_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(3);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		cyc(1);
		reg_wr = 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
		exp_q.push_back({m, x});
		reg_addr = a;
		reg_rd = 1'b1;
		cyc(1);
		reg_rd = 1'b0;
		cyc(1);
	endtask
	task automatic wait_ss();
		int i;
		for (i = 0; i < 20000 && sample_start !== 1'b1; i++) cyc(1);
		if (i == 20000) begin
			chk("sample_start wait", 1, 0);
			test_done();
		end
	endtask
	task automatic period(input int x);
		wait_ss();
		cyc(1);
		wait_ss();
		t0 = cyc_n;
		cyc(1);
		wait_ss();
		chk("sample period", x, cyc_n - t0);
	endtask
	// ********
	// main sequence
	// ********
	initial begin
		{reset, reg_wr, reg_rd, motion_event, quiet_event, result_ready} = 6'h20;
		{result_read_active, buffer_write, buffer_full, buffer_trigger_saved} = 4'h0;
		{reg_addr, reg_wdata, buffer_count, ext_on, pend} = 28'h0;
		output_sample_rate = 3'h3;
		irq_map_a = 6'h01;
		irq_map_b = 6'h3f;
		seed = 32'hf2618ca0;
		repeat (10) @(posedge clk);
		#2 reset = 1'b0;
		cyc(1);
		rd(ADDR_WMARK, 8'hff, WMARK_RESET);
		rd(ADDR_TIMING, 8'hff, TIMING_RESET);
		rd(ADDR_STATUS, 8'hff, 8'h00);
		rd(ADDR_STATUS2, 8'hff, 8'h00);
		rd(8'h7f, 8'hff, 8'h00);
		pulse(result_ready);
		rd(ADDR_STATUS, 8'h01, 8'h01);
		chk("pin a", 2'b11, {a_out, a_oe});
		result_read_active = 1'b1;
		cyc(2);
		rd(ADDR_STATUS, 8'h01, 8'h00);
		pulse(result_ready);
		rd(ADDR_STATUS, 8'h01, 8'h00);
		result_read_active = 1'b0;
		cyc(3);
		rd(ADDR_STATUS, 8'h01, 8'h01);
		pulse(result_read_active);
		chk("pin a", 2'b01, {a_out, a_oe});
		pulse(motion_event);
		pulse(quiet_event);
		chk("pin b", 2'b11, {b_out, b_oe});
		rd(ADDR_STATUS2, 8'h30, 8'h30);
		rd(ADDR_STATUS2, 8'h30, 8'h00);
		seed = lfsr(seed);
		thr = seed[7:0];
		wr(ADDR_WMARK, thr);
		wr(ADDR_BUFCTL, 8'h03);
		buffer_count = {2'b01, thr};
		cyc(3);
		rd(ADDR_STATUS, 8'h06, 8'h06);
		buffer_count = {2'b01, thr} - 10'h1;
		cyc(3);
		rd(ADDR_STATUS, 8'h06, 8'h06);
		rd(ADDR_STATUS, 8'h04, 8'h00);
		wr(ADDR_WMARK, 8'h00);
		wr(ADDR_BUFCTL, 8'h02);
		buffer_count = '0;
		cyc(3);
		rd(ADDR_STATUS, 8'h06, 8'h06);
		rd(ADDR_STATUS, 8'h06, 8'h04);
		wr(ADDR_BUFCTL, 8'h04);
		buffer_count = 10'h5;
		cyc(3);
		rd(ADDR_STATUS, 8'h06, 8'h04);
		rd(ADDR_STATUS, 8'h02, 8'h00);
		buffer_trigger_saved = 1'b1;
		cyc(3);
		rd(ADDR_STATUS, 8'h02, 8'h02);
		wr(ADDR_BUFCTL, 8'h02);
		buffer_full = 1'b1;
		pulse(buffer_write);
		rd(ADDR_STATUS, 8'h08, 8'h08);
		buffer_count = '0;
		rd(ADDR_STATUS, 8'h08, 8'h08);
		rd(ADDR_STATUS, 8'h08, 8'h00);
		wr(ADDR_BUFCTL, 8'h06);
		chk("buffer_mode", 2'b11, buffer_mode);
		pulse(buffer_write);
		rd(ADDR_STATUS, 8'h08, 8'h08);
		wr(ADDR_BUFCTL, 8'h00);
		rd(ADDR_STATUS, 8'h08, 8'h00);
		buffer_full = 1'b0;
		period((TICKS_SLOW >> 3) * BASE_DIV);
		output_sample_rate = RATE_FAST;
		period((TICKS_SLOW >> 3) * FAST_DIV);
		output_sample_rate = 3'h3;
		ext_on = 1'b1;
		wr(ADDR_TIMING, 8'h02);
		cyc(2);
		chk("pin a enable", 0, a_oe);
		period((TICKS_SLOW >> 3) * 2 * i_host.HALF);
		ext_on = 1'b0;
		wr(ADDR_TIMING, 8'h01);
		cyc(2);
		chk("pin b enable", 0, b_oe);
		t0 = n_start;
		i_host.trig();
		i_host.trig();
		chk("sample starts", 2, n_start - t0);
		test_done();
	end
endmodule
